// ---- src/dsf_link.sv ----
// Link-clock shift logic of the serial front end
`timescale 1ns/1ps
module dsf_link
	import dsf_pkg::*;
(
	// Link clock and pins
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic din,
	// Core side
	input wire logic locked,
	input wire logic [FRAME_BITS-1:0] load_word,
	input wire logic load_tgl,
	output logic [FRAME_BITS-1:0] frame_word,
	output logic frame_tgl,
	output logic sdo_bit
);
	import dsf_pkg::*;

	logic [FRAME_BITS-1:0] shreg = SHIFT_RESET_VAL;
	logic [CNT_BITS-1:0] cnt = CNT_RESET_VAL;
	logic full = 1'b0;
	logic load_seen = 1'b0;
	logic out_bit = 1'b0;
	logic [FRAME_BITS-1:0] word_hold = SHIFT_RESET_VAL;
	logic tgl_hold = 1'b0;
	wire logic fresh = (cnt == CNT_RESET_VAL) && !full;
	wire logic reload_now = (load_tgl != load_seen) && fresh;
	wire logic [FRAME_BITS-1:0] src = reload_now ? load_word : shreg;

	// Shift on falling edge while the frame is open
	always_ff @(negedge sclk or posedge sync_n) begin
		if (sync_n) begin
			cnt <= CNT_RESET_VAL;
			full <= 1'b0;
		end else if (!locked) begin
			shreg <= {src[FRAME_BITS-2:0], din};
			cnt <= cnt + 4'h1;
			if (cnt == 4'hF)
				full <= 1'b1;
			if (reload_now)
				load_seen <= load_tgl;
		end
	end

	// Complete frame handed over at frame close
	always_ff @(posedge sync_n) begin
		if (full && cnt == CNT_RESET_VAL) begin
			word_hold <= shreg;
			tgl_hold <= !tgl_hold;
		end
	end

	// Outgoing bit changes on rising edge (mode 0/1)
	always_ff @(posedge sclk) begin
		out_bit <= src[FRAME_BITS-1];
	end

	assign frame_word = word_hold;
	assign frame_tgl = tgl_hold;
	assign sdo_bit = sync_n ? 1'b1 : out_bit;
endmodule : dsf_link

// ---- src/dsf_pkg.sv ----
// Package: constants and types for the serial front end
package dsf_pkg;
	localparam int FRAME_BITS = 16;
	localparam int DATA_BITS = 10;
	localparam int CMD_BITS = 4;
	localparam int CMD_MSB = 13;
	localparam int CMD_LSB = 10;
	localparam int CNT_BITS = 4;
	localparam logic [DATA_BITS-1:0] WIPER_MIDSCALE = 10'h200;
	localparam logic [DATA_BITS-1:0] WIPER_RESET_VAL = 10'h200;
	localparam logic [FRAME_BITS-1:0] SHIFT_RESET_VAL = 16'h0000;
	localparam logic [CNT_BITS-1:0] CNT_RESET_VAL = 4'h0;
	localparam real CLK_MHZ = 200.0;
	localparam real WRITE_BUSY_NS = 410.0;
	localparam real READ_BUSY_NS = 450.0;
	localparam real FUSE_BUSY_MS = 8.0;
	localparam real RELOAD_BUSY_MS = 1.5;
	localparam int WRITE_BUSY_CYC = int'(WRITE_BUSY_NS * CLK_MHZ / 1000.0);
	localparam int READ_BUSY_CYC = int'(READ_BUSY_NS * CLK_MHZ / 1000.0);
	localparam int FUSE_BUSY_CYC = int'(FUSE_BUSY_MS * CLK_MHZ * 1000.0);
	localparam int RELOAD_BUSY_CYC = int'(RELOAD_BUSY_MS * CLK_MHZ * 1000.0);
	localparam int BUSY_BITS = 21;

	typedef enum logic [3:0] {
		DSF_CMD_NOP = 4'h0,
		DSF_CMD_WR_WIPER = 4'h1,
		DSF_CMD_RD_WIPER = 4'h2,
		DSF_CMD_STORE = 4'h3,
		DSF_CMD_RELOAD = 4'h4,
		DSF_CMD_RD_FUSE = 4'h5
	} dsf_cmd_e;

	typedef enum logic [1:0] {
		DSF_IDLE = 2'b00,
		DSF_BUSY = 2'b01
	} dsf_state_e;
endpackage : dsf_pkg

// ---- src/dsf_top.sv ----
// Top: serial front end of a programmable variable resistor
// Function
// - Sample data on falling clock into 16 bits
// - Frame opens on select low, enables shifting
// - Select rise after 16 clocks updates register
// - Early select rise aborts, nothing changes
// - Reset pin rising edge reloads wiper
// - Unprogrammed fuse memory reloads midscale
// - Open-drain data out carries shift contents
// - Open-drain ready high when operation done
// - Readback uses clock polarity 0, phase 1
// - Frame MSB first: 00, command, data
// - Frames must be multiples of 16 bits
// - Fuse store locks shift register until done
// - Read result comes out in next frame
`timescale 1ns/1ps
module dsf_top
	import dsf_pkg::*;
#(
	parameter int FUSE_CYC = FUSE_BUSY_CYC,
	parameter int RELOAD_CYC = RELOAD_BUSY_CYC
) (
	// System
	input wire logic CLK,
	input wire logic SRST,
	// Serial link
	input wire logic SCLK,
	input wire logic SYNC_N,
	input wire logic DIN,
	output logic SDO_O,
	output logic SDO_OE,
	// Ready and reset pin
	output logic RDY_O,
	output logic RDY_OE,
	input wire logic RESET_PIN,
	// Wiper state
	output logic [DATA_BITS-1:0] WIPER,
	output logic FUSE_PROGRAMMED
);
	import dsf_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Crossing registers
	logic [2:0] tgl_sync;
	logic [2:0] rst_sync;
	logic [FRAME_BITS-1:0] frame_word;
	logic frame_tgl;
	logic sdo_bit;
	logic [FRAME_BITS-1:0] load_word;
	logic load_tgl;
	logic lock_core;
	logic [1:0] lock_sync = 2'b00;
	logic [1:0] sdo_sync;

	// Frame toggle and reset pin synchronisers
	always_ff @(posedge CLK) begin
		if (SRST) begin
			tgl_sync <= 3'h0;
			rst_sync <= 3'h7;
		end else begin
			tgl_sync <= {tgl_sync[1:0], frame_tgl};
			rst_sync <= {rst_sync[1:0], RESET_PIN};
		end
	end

	// Lock into link domain: drops at once, rises after two falls,
	// so an idle serial clock cannot leave a stale lock behind
	always_ff @(negedge SCLK or negedge lock_core) begin
		if (!lock_core)
			lock_sync <= 2'b00;
		else
			lock_sync <= {lock_sync[0], 1'b1};
	end

	// Frame toggle edge and reset pin rising edge
	wire logic frame_ev = tgl_sync[2] ^ tgl_sync[1];
	wire logic reset_rise = rst_sync[1] && !rst_sync[2];

	////////////////////////////////////////////////////////////////////////
	// Command decode
	dsf_state_e state;
	logic [BUSY_BITS-1:0] busy_cnt;
	logic [DATA_BITS-1:0] wiper_position_register;
	logic [DATA_BITS-1:0] fuse_store_memory;
	logic fuse_prog;
	logic rdy;

	// Fields of the last complete frame
	wire logic [CMD_BITS-1:0] cmd = frame_word[CMD_MSB:CMD_LSB];
	wire logic [DATA_BITS-1:0] dat = frame_word[DATA_BITS-1:0];
	wire logic take = frame_ev && state == DSF_IDLE;
	wire logic is_wr = cmd == DSF_CMD_WR_WIPER;
	wire logic is_rdw = cmd == DSF_CMD_RD_WIPER;
	wire logic is_st = cmd == DSF_CMD_STORE;
	wire logic is_rl = cmd == DSF_CMD_RELOAD;
	wire logic is_rdf = cmd == DSF_CMD_RD_FUSE;
	wire logic [DATA_BITS-1:0] reload_val =
		fuse_prog ? fuse_store_memory : WIPER_MIDSCALE;
	wire logic [BUSY_BITS-1:0] busy_len =
		is_st ? BUSY_BITS'(FUSE_CYC) :
		is_rl ? BUSY_BITS'(RELOAD_CYC) :
		is_wr ? BUSY_BITS'(WRITE_BUSY_CYC) : BUSY_BITS'(READ_BUSY_CYC);
	wire logic op = is_wr || is_rdw || is_st || is_rl || is_rdf;
	wire logic is_rd = is_rdw || is_rdf;
	wire logic [DATA_BITS-1:0] rd_val =
		is_rdw ? wiper_position_register : fuse_store_memory;
	// Pin reload outranks a frame landing in the same cycle
	wire logic start = take && op && !reset_rise;
	wire logic last_tick = busy_cnt <= BUSY_BITS'(1);
	wire logic finish = state == DSF_BUSY && last_tick;

	// Busy sequencer
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state <= DSF_IDLE;
			busy_cnt <= '0;
		end else if (reset_rise) begin
			state <= DSF_BUSY;
			busy_cnt <= BUSY_BITS'(RELOAD_CYC);
		end else begin
			case (state)
				DSF_IDLE: begin
					if (start) begin
						state <= DSF_BUSY;
						busy_cnt <= busy_len;
					end
				end
				DSF_BUSY: begin
					if (last_tick)
						state <= DSF_IDLE;
					else
						busy_cnt <= busy_cnt - BUSY_BITS'(1);
				end
				default: state <= DSF_IDLE;
			endcase
		end
	end

	// Ready and shift lock
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdy <= 1'b1;
			lock_core <= 1'b0;
		end else if (reset_rise) begin
			rdy <= 1'b0;
		end else if (start) begin
			rdy <= 1'b0;
			lock_core <= is_st;
		end else if (finish) begin
			rdy <= 1'b1;
			lock_core <= 1'b0;
		end
	end

	// Wiper position
	always_ff @(posedge CLK) begin
		if (SRST)
			wiper_position_register <= WIPER_RESET_VAL;
		else if (reset_rise)
			wiper_position_register <= reload_val;
		else if (start && is_wr)
			wiper_position_register <= dat;
		else if (start && is_rl)
			wiper_position_register <= reload_val;
	end

	// Fuse store
	always_ff @(posedge CLK) begin
		if (SRST) begin
			fuse_store_memory <= WIPER_MIDSCALE;
			fuse_prog <= 1'b0;
		end else if (start && is_st) begin
			fuse_store_memory <= wiper_position_register;
			fuse_prog <= 1'b1;
		end
	end

	// Readback word for the next frame
	always_ff @(posedge CLK) begin
		if (SRST) begin
			load_word <= SHIFT_RESET_VAL;
			load_tgl <= 1'b0;
		end else if (start && is_rd) begin
			load_word <= {6'h00, rd_val};
			load_tgl <= !load_tgl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Link logic and pin drivers
	dsf_link u_link (
		.sclk(SCLK),
		.sync_n(SYNC_N),
		.din(DIN),
		.locked(lock_sync[1]),
		.load_word(load_word),
		.load_tgl(load_tgl),
		.frame_word(frame_word),
		.frame_tgl(frame_tgl),
		.sdo_bit(sdo_bit)
	);

	// Registered pin drivers
	always_ff @(posedge CLK) begin
		if (SRST) begin
			sdo_sync <= 2'b11;
			SDO_O <= 1'b0;
			SDO_OE <= 1'b0;
			RDY_O <= 1'b0;
			RDY_OE <= 1'b0;
			WIPER <= WIPER_RESET_VAL;
			FUSE_PROGRAMMED <= 1'b0;
		end else begin
			sdo_sync <= {sdo_sync[0], sdo_bit};
			SDO_O <= 1'b0;
			SDO_OE <= !sdo_sync[1];
			RDY_O <= 1'b0;
			RDY_OE <= !rdy;
			WIPER <= wiper_position_register;
			FUSE_PROGRAMMED <= fuse_prog;
		end
	end
endmodule : dsf_top

// ---- testbench/dsf_host_model.sv ----
// Serial host controller model
`timescale 1ns/1ps
module dsf_host_model (
	// Link pins
	output logic sclk,
	output logic sync_n,
	output logic din,
	input wire logic serial_data_out
);
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		din = 1'b0;
	end
	// Frame of n bits at 64 ns, clock still outside
	task automatic xfer(input logic [31:0] w, input int n,
		output logic [31:0] r);
		r = 32'h0;
		sync_n = 1'b0;
		#32;
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b1;
			din = w[i];
			#32;
			sclk = 1'b0;
			r = {r[30:0], serial_data_out};
			#32;
		end
		sync_n = 1'b1;
		din = ~din;
	endtask : xfer
endmodule : dsf_host_model

// ---- testbench/dsf_sva.sv ----
// Port assertions for the serial front end
`timescale 1ns/1ps
module dsf_sva
	import dsf_pkg::*;
#(
	parameter int FUSE_CYC = 1,
	parameter int RELOAD_CYC = 1
) (
	// Watched ports
	input wire logic CLK,
	input wire logic SRST,
	input wire logic SYNC_N,
	input wire logic SDO_O,
	input wire logic SDO_OE,
	input wire logic RDY_O,
	input wire logic RDY_OE,
	input wire logic RESET_PIN,
	input wire logic [DATA_BITS-1:0] WIPER,
	input wire logic FUSE_PROGRAMMED
);
	int busy_cnt;
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	// Length of each busy stretch
	always_ff @(posedge CLK)
		busy_cnt <= (SRST || !RDY_OE) ? 0 : busy_cnt + 1;
	property p_sdo; SDO_O == 1'b0; endproperty
	a_sdo: assert property (p_sdo) else $error("sdo high");
	property p_rdy; RDY_O == 1'b0; endproperty
	a_rdy: assert property (p_rdy) else $error("ready high");
	property p_rst;
		$past(SRST) |-> !RDY_OE && !SDO_OE && WIPER == WIPER_RESET_VAL;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_wip; !$stable(WIPER) |-> SYNC_N; endproperty
	a_wip: assert property (p_wip) else $error("wiper in frame");
	property p_len;
		$fell(RDY_OE) |-> busy_cnt inside
			{WRITE_BUSY_CYC, READ_BUSY_CYC, FUSE_CYC, RELOAD_CYC};
	endproperty
	a_len: assert property (p_len) else $error("busy length");
	property p_pin; $rose(RESET_PIN) |-> ##[1:6] RDY_OE; endproperty
	a_pin: assert property (p_pin) else $error("pin reload");
	property p_frm; $rose(RDY_OE) |-> SYNC_N; endproperty
	a_frm: assert property (p_frm) else $error("busy in frame");
	property p_fuse; !$fell(FUSE_PROGRAMMED); endproperty
	a_fuse: assert property (p_fuse) else $error("fuse flag");
	c_store: cover property ($fell(RDY_OE) && busy_cnt == FUSE_CYC);
	c_pin: cover property ($rose(RESET_PIN));
	c_fuse: cover property ($rose(FUSE_PROGRAMMED));
endmodule : dsf_sva
bind dsf_top dsf_sva #(.FUSE_CYC(FUSE_CYC), .RELOAD_CYC(RELOAD_CYC)) u_sva (
	.CLK(CLK), .SRST(SRST), .SYNC_N(SYNC_N), .SDO_O(SDO_O),
	.SDO_OE(SDO_OE), .RDY_O(RDY_O), .RDY_OE(RDY_OE),
	.RESET_PIN(RESET_PIN), .WIPER(WIPER),
	.FUSE_PROGRAMMED(FUSE_PROGRAMMED));

// ---- testbench/tb_top.sv ----
// Self-checking bench for the serial front end
`timescale 1ns/1ps
module tb_top;
	import dsf_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic rpin = 1'b0;
	logic sclk, sync_n, din, sdo_o, sdo_oe, rdy_o, rdy_oe, fprog;
	logic [DATA_BITS-1:0] wiper;
	logic [31:0] rd;
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;
	wire serial_data_out = sdo_oe ? sdo_o : 1'b1;
	wire rdy = rdy_oe ? rdy_o : 1'b1;
	initial forever #2.5 clk = ~clk;
	dsf_top #(.FUSE_CYC(1000), .RELOAD_CYC(100)) u_dut (.CLK(clk),
		.SRST(srst), .SCLK(sclk), .SYNC_N(sync_n), .DIN(din),
		.SDO_O(sdo_o), .SDO_OE(sdo_oe), .RDY_O(rdy_o), .RDY_OE(rdy_oe),
		.RESET_PIN(rpin), .WIPER(wiper), .FUSE_PROGRAMMED(fprog));
	dsf_host_model u_host (.sclk(sclk), .sync_n(sync_n), .din(din),
		.serial_data_out(serial_data_out));
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t exp %h got %h", $time, e, g);
		end
	endtask : chk
	task automatic close_out;
		if (miscompares == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	function automatic logic [31:0] wd(logic [3:0] c, logic [9:0] d);
		return {18'h0, c, d};
	endfunction : wd
	// Wait out busy, then keep select high a while
	task automatic idle;
		int n = 0;
		repeat (8) @(posedge clk);
		while (rdy !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
		end
		chk(1, rdy);
		repeat (80) @(posedge clk);
	endtask : idle
	task automatic fr(input logic [31:0] w, input int n);
		u_host.xfer(w, n, rd);
		idle();
	endtask : fr
	task automatic t_write;
		logic [9:0] v[3] = '{10'h155, 10'h3FF, 10'h000};
		foreach (v[i]) begin
			fr(wd(DSF_CMD_WR_WIPER, v[i]), 16);
			chk(v[i], wiper);
		end
		fr(wd(DSF_CMD_WR_WIPER, 10'h0AA), 15);
		chk(10'h000, wiper);
		fr(wd(DSF_CMD_WR_WIPER, 10'h2C7), 32);
		chk(10'h2C7, wiper);
	endtask : t_write
	task automatic t_read;
		fr(wd(DSF_CMD_RD_WIPER, 10'h000), 16);
		fr(wd(DSF_CMD_NOP, 10'h000), 16);
		chk(32'h2C7, rd);
		fr(wd(DSF_CMD_RD_FUSE, 10'h000), 16);
		fr(wd(DSF_CMD_NOP, 10'h000), 16);
	endtask : t_read
	task automatic t_reload(input logic [9:0] e);
		fr(wd(DSF_CMD_WR_WIPER, 10'h111), 16);
		chk(10'h111, wiper);
		fr(wd(DSF_CMD_RELOAD, 10'h000), 16);
		chk(e, wiper);
		fr(wd(DSF_CMD_WR_WIPER, 10'h3FF), 16);
		@(negedge clk) rpin = 1'b1;
		repeat (5) @(negedge clk);
		rpin = 1'b0;
		idle();
		chk(e, wiper);
	endtask : t_reload
	task automatic t_store;
		fr(wd(DSF_CMD_WR_WIPER, 10'h0F0), 16);
		u_host.xfer(wd(DSF_CMD_STORE, 10'h000), 16, rd);
		repeat (8) @(posedge clk);
		fr(wd(DSF_CMD_WR_WIPER, 10'h001), 16);
		chk(10'h0F0, wiper);
		chk(1, fprog);
		fr(wd(DSF_CMD_RD_FUSE, 10'h000), 16);
		fr(wd(DSF_CMD_NOP, 10'h000), 16);
		chk(32'h0F0, rd);
	endtask : t_store
	always @(posedge clk) begin
		cyc++;
		if (cyc > 30000) begin
			miscompares++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(negedge clk);
		srst = 1'b0;
		repeat (4) @(negedge clk);
		chk(WIPER_RESET_VAL, wiper);
		chk(0, fprog);
		t_write();
		t_read();
		t_reload(WIPER_MIDSCALE);
		t_store();
		t_reload(10'h0F0);
		close_out();
	end
endmodule : tb_top
